// file: core/health_word.sv
// Built-in test health word, alert summary and attitude phase control
`timescale 1ns/10ps
`include "health_defs.svh"
module health_word #(
    parameter int unsigned INIT_CYCLES = `INIT_CYCLES,
    parameter int unsigned UPDATE_CYCLES = `UPDATE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic fatal_in,
    input wire logic hw_fault_in,
    input wire logic link_fault_in,
    input wire logic sw_fault_in,
    output logic [15:0] packet_health,
    output logic packet_send,
    output logic diag_send,
    output logic orient_update,
    output logic turn_detect,
    output logic low_gain,
    output health_pkg::alg_state_type alg_state
);
    import health_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [7:0] ctrl_r;
    logic [3:0] fault_r;
    logic [15:0] rate_r [3];
    logic [15:0] rate_limit_r;
    logic [15:0] turn_thresh_r;
    logic [31:0] hrdata_r;
    logic [1:0] cmd_pulse_r;
    logic [3:0] pin_sync_r;
    logic [3:0] pin_m1_r;
    wire take = hsel && hready && htrans[1];
    wire wr_take = take && hwrite;
    wire rd_take = take && !hwrite;
    wire wr_ctrl = wr_pend_r && wr_addr_r == `OFS_CTRL;
    wire wr_fault = wr_pend_r && wr_addr_r == `OFS_FAULT_IN;
    wire wr_limits = wr_pend_r && wr_addr_r == `OFS_LIMITS;
    wire wr_cmd = wr_pend_r && wr_addr_r == `OFS_CMD;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // External fault pins are asynchronous: two stages first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_m1_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_m1_r <= {sw_fault_in, link_fault_in, hw_fault_in, fatal_in};
            pin_sync_r <= pin_m1_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= haddr;
        end
    end

    // Rate sensor words for the three axes
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_rate
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    rate_r[gi] <= 16'h0000;
                end else if (wr_pend_r && wr_addr_r == 8'(`OFS_RATE_X + 4 * gi)) begin
                    rate_r[gi] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `CTRL_RESET;
            fault_r <= 4'h0;
            rate_limit_r <= 16'hffff;
            turn_thresh_r <= 16'hffff;
            cmd_pulse_r <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= hwdata[7:0];
            end
            if (wr_fault) begin
                fault_r <= hwdata[3:0];
            end
            if (wr_limits) begin
                rate_limit_r <= hwdata[15:0];
                turn_thresh_r <= hwdata[31:16];
            end
            cmd_pulse_r <= wr_cmd ? hwdata[1:0] : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Over-range on rate sensors only
    // ------------------------------------------------------------
    function automatic logic [15:0] mag(input logic [15:0] v);
        mag = v[15] ? 16'(-v) : v;
    endfunction
    // Accelerometer data never enters here: vibration would trip it falsely
    logic [2:0] axis_over;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_over
            assign axis_over[gi] = mag(rate_r[gi]) > rate_limit_r;
        end
    endgenerate
    wire over_range = |axis_over;

    // ------------------------------------------------------------
    // Update tick and algorithm phase
    // ------------------------------------------------------------
    logic [31:0] upd_cnt_r;
    logic [31:0] init_cnt_r;
    alg_state_type alg_r;
    wire tick = upd_cnt_r == 32'(UPDATE_CYCLES - 1);
    wire restart = cmd_pulse_r[`CMD_RESTART];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upd_cnt_r <= 32'h0;
        end else begin
            upd_cnt_r <= tick ? 32'h0 : upd_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alg_r <= ALG_RESET;
            init_cnt_r <= 32'h0;
        end else if (restart) begin
            alg_r <= ALG_RESET;
            init_cnt_r <= 32'h0;
        end else begin
            case (alg_r)
                ALG_RESET: begin
                    alg_r <= ALG_INIT;
                    init_cnt_r <= 32'h0;
                end
                ALG_INIT: begin
                    if (init_cnt_r >= INIT_CYCLES - 1) begin
                        alg_r <= ALG_RUN;
                    end
                    init_cnt_r <= init_cnt_r + 32'h1;
                end
                default: begin
                    alg_r <= ALG_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Turn detection
    // ------------------------------------------------------------
    logic [15:0] yaw_mag;
    logic yaw_over;
    yaw_filter u_yaw (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(restart),
        .tick(tick),
        .yaw_rate(rate_r[2]),
        .threshold(turn_thresh_r),
        .filtered_mag(yaw_mag),
        .over(yaw_over)
    );

    // ------------------------------------------------------------
    // Health word
    // ------------------------------------------------------------
    wire [3:0] errs = fault_r | pin_sync_r;
    // Software alert covers initialisation and turn coasting
    wire sw_cond = alg_r != ALG_RUN || yaw_over;
    wire [3:0] cats = {over_range, sw_cond, errs[2], errs[1]};
    wire [3:0] en = ctrl_r[3:0];
    wire [3:0] alerts = cats & {en[`CTRL_EN_SENSOR], en[`CTRL_EN_SW], en[`CTRL_EN_LINK],
        en[`CTRL_EN_HW]};
    wire [15:0] health_nxt = {3'h0, alerts, |alerts, 4'h0,
        errs[3], errs[2], errs[1], errs[0]};

    // ------------------------------------------------------------
    // Packet pacing
    // ------------------------------------------------------------
    logic [6:0] pace_r;
    logic [6:0] div;
    pkt_rate_type rate_sel;
    assign rate_sel = pkt_rate_type'(ctrl_r[`CTRL_RATE_LSB +: 3]);
    always_comb begin
        case (rate_sel)
            RATE_100: div = 7'd2;
            RATE_50: div = 7'd4;
            RATE_25: div = 7'd8;
            RATE_20: div = 7'd10;
            RATE_10: div = 7'd20;
            RATE_5: div = 7'd40;
            RATE_2: div = 7'd100;
            default: div = 7'd0;
        endcase
    end
    wire pace_hit = tick && div != 7'd0 && pace_r + 7'd1 >= div;
    wire fetch = cmd_pulse_r[`CMD_FETCH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_r <= 7'h00;
        end else if (tick) begin
            pace_r <= pace_hit ? 7'h00 : pace_r + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            packet_health <= 16'h0000;
            packet_send <= 1'b0;
            diag_send <= 1'b0;
            orient_update <= 1'b0;
            turn_detect <= 1'b0;
            low_gain <= 1'b0;
            alg_state <= ALG_RESET;
        end else begin
            packet_send <= pace_hit || fetch;
            diag_send <= fetch;
            packet_health <= health_nxt;
            orient_update <= tick;
            turn_detect <= yaw_over;
            low_gain <= yaw_over;
            alg_state <= alg_r;
        end
    end

    // ------------------------------------------------------------
    // Read data: chosen in the address phase, held through the data phase
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        if (haddr == `OFS_CTRL) begin
            rd_word = {24'h0, ctrl_r};
        end else if (haddr == `OFS_HEALTH) begin
            rd_word = {16'h0, health_nxt};
        end else if (haddr == `OFS_FAULT_IN) begin
            rd_word = {28'h0, fault_r};
        end else if (haddr == `OFS_RATE_X) begin
            rd_word = {16'h0, rate_r[0]};
        end else if (haddr == `OFS_RATE_Y) begin
            rd_word = {16'h0, rate_r[1]};
        end else if (haddr == `OFS_RATE_Z) begin
            rd_word = {16'h0, rate_r[2]};
        end else if (haddr == `OFS_LIMITS) begin
            rd_word = {turn_thresh_r, rate_limit_r};
        end else if (haddr == `OFS_STATE) begin
            rd_word = {yaw_mag, 13'h0, yaw_over, alg_r};
        end else begin
            rd_word = 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (rd_take) begin
            hrdata_r <= rd_word;
        end
    end
endmodule // health_word

// file: core/health_defs.svh
// Offsets, field positions, reset values and timing counts for the health word block
`ifndef HEALTH_DEFS_SVH
`define HEALTH_DEFS_SVH
`define CLK_HZ 25000000
`define INIT_TIME_S 60
`define INIT_CYCLES (`INIT_TIME_S * `CLK_HZ)
`define UPDATE_RATE_HZ 200
`define UPDATE_CYCLES (`CLK_HZ / `UPDATE_RATE_HZ)
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_HEALTH 8'h04
`define OFS_FAULT_IN 8'h08
`define OFS_RATE_X 8'h0c
`define OFS_RATE_Y 8'h10
`define OFS_RATE_Z 8'h14
`define OFS_LIMITS 8'h18
`define OFS_STATE 8'h1c
`define OFS_CMD 8'h20
// Health word fields
`define BIT_FATAL 0
`define BIT_HW_FAULT 1
`define BIT_LINK_FAULT 2
`define BIT_SW_FAULT 3
`define BIT_SUMMARY 8
`define BIT_HW_ALERT 9
`define BIT_LINK_ALERT 10
`define BIT_SW_ALERT 11
`define BIT_SENSOR_ALERT 12
// Control register fields
`define CTRL_EN_HW 0
`define CTRL_EN_LINK 1
`define CTRL_EN_SW 2
`define CTRL_EN_SENSOR 3
`define CTRL_RATE_LSB 4
`define CTRL_RESET 8'h08
// Command register bits
`define CMD_RESTART 0
`define CMD_FETCH 1
`endif

// file: core/health_pkg.sv
// Types shared by the health word block
package health_pkg;
    typedef enum logic [2:0] {
        RATE_100, RATE_50, RATE_25, RATE_20, RATE_10, RATE_5, RATE_2, RATE_QUIET
    } pkt_rate_type;
    typedef enum logic [1:0] {
        ALG_RESET, ALG_INIT, ALG_RUN
    } alg_state_type;
endpackage

// file: core/yaw_filter.sv
// First-order low-pass filter on the yaw rate with threshold compare
`timescale 1ns/10ps
module yaw_filter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic tick,
    input wire logic signed [15:0] yaw_rate,
    input wire logic [15:0] threshold,
    output logic [15:0] filtered_mag,
    output logic over
);
    logic signed [19:0] acc_r;
    logic signed [19:0] acc_nxt;
    logic signed [15:0] avg;
    assign avg = acc_r[19:4];
    // Filter state is avg*16; each tick moves 1/16 toward the input
    assign acc_nxt = acc_r - 20'(avg) + 20'(yaw_rate);
    assign filtered_mag = avg[15] ? 16'(-avg) : 16'(avg);
    assign over = filtered_mag > threshold;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= 20'h00000;
        end else if (clear) begin
            acc_r <= 20'h00000;
        end else if (tick) begin
            acc_r <= acc_nxt;
        end
    end
endmodule // yaw_filter

// file: testbench/health_word_properties.sv
// Port-level assertions for the health word block
`timescale 1ns/10ps
`include "health_defs.svh"
module health_word_checker #(
    parameter int unsigned INIT_CYCLES = 200
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic fatal_in,
    input wire logic hw_fault_in,
    input wire logic [15:0] packet_health,
    input wire logic diag_send,
    input wire logic turn_detect,
    input wire logic low_gain,
    input wire health_pkg::alg_state_type alg_state
);
    import health_pkg::*;
    logic cmd_r;
    int unsigned icnt_r;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Init length is judged with a slack of two cycles, as phase edges are registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_r <= 1'b0;
            icnt_r <= 0;
        end else begin
            cmd_r <= hsel && hready && htrans[1] && hwrite && haddr == `OFS_CMD;
            icnt_r <= (alg_state == ALG_INIT) ? icnt_r + 1 : 0;
        end
    end
    AST_RSVD: assert property ((packet_health & 16'he0f0) == 16'h0000)
        else $error("reserved health bits set");
    AST_FATAL: assert property (fatal_in [*4] |-> packet_health[0])
        else $error("fatal fault not shown");
    AST_HW: assert property (hw_fault_in [*4] |-> packet_health[1])
        else $error("hardware fault not shown");
    AST_SUMMARY: assert property (packet_health[8] |-> |packet_health[12:9])
        else $error("summary alert without any alert");
    AST_TURN_GAIN: assert property (turn_detect == low_gain)
        else $error("turn flag and gain cut disagree");
    AST_INIT_MAX: assert property (alg_state == ALG_INIT |-> icnt_r <= INIT_CYCLES + 2)
        else $error("init phase too long");
    AST_INIT_MIN: assert property ($rose(alg_state == ALG_RUN) |-> icnt_r + 2 >= INIT_CYCLES)
        else $error("init phase too short");
    AST_RESTART: assert property (cmd_r && hwdata[0] |->
        ##[1:5] alg_state == ALG_RESET ##[1:5] alg_state == ALG_INIT)
        else $error("restart did not re-enter init");
    AST_FETCH: assert property (cmd_r && hwdata[1] |-> ##[1:4] diag_send)
        else $error("fetch gave no diagnostic packet");
    cover property ($rose(alg_state == ALG_RUN));
    cover property (packet_health[12] && packet_health[8]);
    cover property (cmd_r && hwdata[0]);
    cover property (turn_detect && alg_state == ALG_RUN);
endmodule // health_word_checker

bind health_word health_word_checker #(.INIT_CYCLES(INIT_CYCLES)) i_health_word_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .fatal_in(fatal_in),
    .hw_fault_in(hw_fault_in), .packet_health(packet_health), .diag_send(diag_send),
    .turn_detect(turn_detect), .low_gain(low_gain), .alg_state(alg_state)
);

// file: testbench/host_reader.sv
// Host model that collects measurement and diagnostic packets
`timescale 1ns/10ps
module host_reader (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] packet_health,
    input wire logic packet_send,
    input wire logic diag_send,
    output int n_pkt,
    output int n_diag,
    output logic [15:0] last_health
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_pkt <= 0;
            n_diag <= 0;
            last_health <= 16'h0000;
        end else begin
            if (packet_send) begin
                n_pkt <= n_pkt + 1;
                last_health <= packet_health;
            end
            if (diag_send) n_diag <= n_diag + 1;
        end
    end
endmodule // host_reader

// file: testbench/builtin_test_status_word_tb_top.sv
// Self-checking bench for the health word block
`timescale 1ns/10ps
`include "health_defs.svh"
module builtin_test_status_word_tb_top;
    import health_pkg::*;
    // Short init phase keeps the run brief
    localparam int INIT = 2000;
    // Short update period so that pacing and turn filtering show within the run
    localparam int UPD = 50;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] flt = 4'h0;
    wire logic hready;
    logic [31:0] hrdata, rd;
    logic [15:0] ph, last_health;
    logic packet_send, diag_send;
    alg_state_type alg_state;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_pkt, n_diag, t0;
    int n_upd = 0;
    int n_exp, k0;
    logic orient_update, turn_detect, low_gain, hresp;
    always #20 hclk = ~hclk;
    always @(posedge hclk) cyc++;
    always @(posedge hclk) begin
        if (orient_update) n_upd <= n_upd + 1;
    end
    health_word #(.INIT_CYCLES(INIT), .UPDATE_CYCLES(UPD)) i_health_word (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .fatal_in(flt[0]), .hw_fault_in(flt[1]),
        .link_fault_in(flt[2]), .sw_fault_in(flt[3]), .packet_health(ph),
        .packet_send(packet_send), .diag_send(diag_send), .orient_update(orient_update),
        .turn_detect(turn_detect), .low_gain(low_gain), .alg_state(alg_state)
    );
    host_reader i_host_reader (
        .hclk(hclk), .hresetn(hresetn), .packet_health(ph), .packet_send(packet_send),
        .diag_send(diag_send), .n_pkt(n_pkt), .n_diag(n_diag), .last_health(last_health)
    );
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                n_errors++;
                close_out;
            end
            @(posedge hclk);
        end
    endtask
    // Entered just after a rising edge; read data is taken at the data phase's edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
        check("hresp", hresp, 0);
    endtask
    task automatic wait_alg(input alg_state_type s, input int lim);
        int k;
        for (k = 0; alg_state !== s; k++) begin
            if (k > lim) begin
                n_errors++;
                close_out;
            end
            @(posedge hclk);
        end
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t0 = cyc;
        xfer(0, `OFS_CTRL, 0);
        check("ctrl reset", rd, 32'h8);
        idle(3);
        check("summary idle", ph[8], 0);
        for (int i = 0; i < 4; i++) begin
            xfer(1, `OFS_FAULT_IN, 1 << i);
            idle(3);
            check("reg fault", ph[7:0], 1 << i);
            xfer(0, `OFS_HEALTH, 0);
            check("health reg", rd[7:0], 1 << i);
            xfer(1, `OFS_FAULT_IN, 0);
            flt <= 4'h1 << i;
            idle(6);
            check("pin fault", ph[7:0], 1 << i);
            flt <= 4'h0;
        end
        for (int i = 0; i < 3; i++) begin
            xfer(1, `OFS_FAULT_IN, 2 << i);
            xfer(1, `OFS_CTRL, 0);
            idle(3);
            check("alert off", ph[8], 0);
            xfer(1, `OFS_CTRL, 1 << i);
            idle(3);
            check("alert on", ph[8], 1);
        end
        xfer(1, `OFS_FAULT_IN, 0);
        xfer(1, `OFS_CTRL, 32'h8);
        xfer(1, `OFS_LIMITS, 32'hffff_0064);
        for (int i = 0; i < 3; i++) begin
            xfer(1, 8'(`OFS_RATE_X + 4 * i), (i == 1) ? 32'h0000_ff38 : 200);
            idle(3);
            check("over-range", {ph[12], ph[8]}, 2'b11);
            check("reserved", ph & 16'he0f0, 0);
            xfer(1, 8'(`OFS_RATE_X + 4 * i), 0);
            idle(3);
            check("in range", ph[12], 0);
        end
        xfer(0, 8'h40, 0);
        check("unmapped", rd, 0);
        wait_alg(ALG_RUN, INIT + 100);
        check("init time", cyc - t0 > INIT - 20 && cyc - t0 < INIT + 20, 1);
        xfer(1, `OFS_CMD, 1);
        t0 = cyc;
        wait_alg(ALG_INIT, 20);
        wait_alg(ALG_RUN, INIT + 100);
        check("re-init", cyc - t0 > INIT - 20 && cyc - t0 < INIT + 20, 1);
        // Turn detection with only the software category enabled
        xfer(1, `OFS_LIMITS, 32'h0064_ffff);
        xfer(1, `OFS_CTRL, 32'h4);
        idle(3);
        check("no turn", {turn_detect, low_gain, ph[11], ph[8]}, 0);
        xfer(1, `OFS_RATE_Z, 32'h0800);
        idle(3 * UPD);
        check("turn", {turn_detect, low_gain, ph[11], ph[8]}, 4'hf);
        xfer(0, `OFS_STATE, 0);
        check("turn state", rd[2], 1);
        check("yaw level", rd[31:16] > 100, 1);
        // Packet pacing at 100 Hz, 20 Hz and quiet, against 200 updates per second
        xfer(1, `OFS_FAULT_IN, 32'h2);
        for (int r = 0; r < 3; r++) begin
            xfer(1, `OFS_CTRL, (r == 0) ? 32'h08 : (r == 1) ? 32'h38 : 32'h78);
            idle(12 * UPD);
            t0 = n_pkt;
            k0 = n_upd;
            idle(1000);
            n_exp = (r == 2) ? 0 : 1000 * (r ? 20 : 100) / (200 * UPD);
            check("packet rate", n_pkt - t0, n_exp);
            check("update rate", n_upd - k0, 1000 / UPD);
            check("packet word", last_health, 16'h0002);
        end
        xfer(1, `OFS_FAULT_IN, 0);
        t0 = n_diag;
        k0 = n_pkt;
        xfer(1, `OFS_CMD, 2);
        idle(6);
        check("diag count", n_diag, t0 + 1);
        check("fetch packet", n_pkt, k0 + 1);
        close_out;
    end
endmodule // builtin_test_status_word_tb_top
